//--- common/astr_map.svh
// register offsets, field positions, reset values and timing counts of the serial unit
`ifndef ASTR_MAP_SVH
`define ASTR_MAP_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define ASTR_OFS_CTL_ONE 12'h000
`define ASTR_OFS_CTL_TWO 12'h004
`define ASTR_OFS_CTL_THREE 12'h008
`define ASTR_OFS_STAT_ONE 12'h00C
`define ASTR_OFS_STAT_TWO 12'h010
`define ASTR_OFS_DATA 12'h014
`define ASTR_OFS_BAUD 12'h018
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ASTR_C1_ENABLE 0
`define ASTR_C1_NINE 1
`define ASTR_C1_FLIP 2
`define ASTR_C1_EXTBRK 3
`define ASTR_C1_BAUDSRC 4
`define ASTR_C2_TXON 0
`define ASTR_C2_RXON 1
`define ASTR_C2_TIE 2
`define ASTR_C2_RIE 3
`define ASTR_C2_BREAK 4
`define ASTR_C3_TX9 0
`define ASTR_C3_RX9 1
`define ASTR_S1_TXE 0
`define ASTR_S1_TC 1
`define ASTR_S1_RXF 2
`define ASTR_S1_OVR 3
`define ASTR_S1_NOISE 4
`define ASTR_S1_FRAME 5
`define ASTR_S1_RXBUSY 6
`define ASTR_S2_BRK 0
// ------------------------------------------------------------
// reset values and timing counts
// ------------------------------------------------------------
`define ASTR_RST_CTL_ONE 5'h00
`define ASTR_RST_CTL_TWO 5'h00
`define ASTR_RST_BAUD 16'h001A
`define ASTR_RT_PER_BIT 4'hF
`define ASTR_BUS_DIV 2'h3
`endif

//--- common/astr_pkg.sv
// types shared by the serial unit
package astr_pkg;
  typedef enum logic [1:0] {
    ASTR_TX_IDLE = 2'b01,
    ASTR_TX_SHIFT = 2'b10
  } astr_tx_state_e;
  typedef enum logic [2:0] {
    ASTR_RX_IDLE = 3'b001,
    ASTR_RX_START = 3'b010,
    ASTR_RX_DATA = 3'b100
  } astr_rx_state_e;
endpackage : astr_pkg

//--- verif/astr_remote.sv
// remote serial peer: frame decoder on the transmit line, frame sender on the receive line
`timescale 1ns/10ps
`default_nettype none
module astr_remote #(
  parameter int BIT = 16
) (
  // clock
  input wire logic clk,
  // line from the unit
  input wire logic line,
  input wire logic nine,
  // line to the unit
  output logic rxd
);
  logic [10:0] frame = 11'h000;
  int frames = 0;
  int run = 0;
  int last_run = 0;
  initial rxd = 1'b1;
  // ------------------------------------------------------------
  // decoder
  // ------------------------------------------------------------
  // length of the latest zero run, for break sizing
  always @(posedge clk) begin
    if (line === 1'b0) begin
      run <= run + 1;
    end else begin
      if (run != 0) last_run <= run;
      run <= 0;
    end
  end
  // mid-bit sampling, lsb first, stop bit lands in the slot just above the data bits
  always begin
    @(posedge clk);
    if (line === 1'b0) begin
      repeat (BIT / 2) @(posedge clk);
      if (line === 1'b0) begin
        for (int i = 0; i < 9 + int'(nine); i++) begin
          repeat (BIT) @(posedge clk);
          frame[i] = line;
        end
        frames++;
      end
    end
  end
  // ------------------------------------------------------------
  // sender
  // ------------------------------------------------------------
  // line returns to its pulled-up rest level after the last bit
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rxd <= bits[i];
      repeat (BIT - 1) @(posedge clk);
    end
    @(posedge clk);
    rxd <= 1'b1;
  endtask : send
endmodule : astr_remote
`default_nettype wire

//--- verif/astr_serial_test.sv
// self-checking bench for the serial unit: apb accesses and a remote peer on the lines
`include "astr_map.svh"
`timescale 1ns/10ps
`default_nettype none
module astr_serial_test;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready, pslverr, txd_o, txd_oe, rxd_oe, tx_irq, rx_irq, rxd, err;
  logic nine = 1'b0;
  wire line;
  int error_cnt = 0;
  int checks = 0;
  int cyc;
  // undriven transmit pin rests high through its pull-up
  assign line = txd_oe ? txd_o : 1'b1;
  always #10 clk = ~clk;

  astr_serial i_astr_serial (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txd_o(txd_o), .txd_oe(txd_oe), .rxd_i(rxd), .rxd_oe(rxd_oe),
    .tx_irq(tx_irq), .rx_irq(rx_irq));
  astr_remote i_astr_remote (.clk(clk), .line(line), .nine(nine), .rxd(rxd));

  // ------------------------------------------------------------
  // access and compare tasks
  // ------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) error_cnt++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // waits for the peer to decode one more frame, counting cycles
  task automatic wait_tx();
    int f;
    f = i_astr_remote.frames;
    cyc = 0;
    while (i_astr_remote.frames == f && cyc < 3000) begin
      @(posedge clk);
      cyc++;
    end
    if (cyc >= 3000) error_cnt++;
  endtask : wait_tx
  task automatic wait_rx();
    int n;
    n = 0;
    q = 32'h0;
    while (q[2] !== 1'b1 && n < 200) begin
      rd(`ASTR_OFS_STAT_ONE);
      n++;
    end
    if (q[2] !== 1'b1) error_cnt++;
  endtask : wait_rx
  task automatic summarize();
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    #1000000;
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    cmp({31'h0, txd_oe}, 32'h0);
    rd(`ASTR_OFS_STAT_ONE);
    cmp(q & 32'h1, 32'h1);
    rd(`ASTR_OFS_BAUD);
    cmp(q, 32'h001A);
    rd(12'h01C);
    cmp({31'h0, err}, 32'h1);
    wr(`ASTR_OFS_BAUD, 32'h1);
    wr(`ASTR_OFS_CTL_ONE, 32'h01);
    wr(`ASTR_OFS_CTL_TWO, 32'h0F);
    #1;
    cmp({31'h0, tx_irq}, 32'h1);
    rd(`ASTR_OFS_STAT_ONE);
    wr(`ASTR_OFS_DATA, 32'hA5);
    wait_tx();
    cmp(32'(cyc > 300), 32'h1);
    cmp({23'h0, i_astr_remote.frame[8:0]}, {23'h0, 1'b1, 8'hA5});
    cmp({31'h0, line}, 32'h1);
    nine = 1'b1;
    wr(`ASTR_OFS_CTL_ONE, 32'h03);
    wr(`ASTR_OFS_CTL_THREE, 32'h01);
    rd(`ASTR_OFS_STAT_ONE);
    wr(`ASTR_OFS_DATA, 32'h3C);
    wait_tx();
    cmp({22'h0, i_astr_remote.frame[9:0]}, {22'h0, 2'b11, 8'h3C});
    // receive 9-bit then 8-bit, ninth bit source differs
    i_astr_remote.send({1'b1, 1'b0, 8'hC3, 1'b0}, 11);
    wait_rx();
    cmp({31'h0, rx_irq}, 32'h1);
    rd(`ASTR_OFS_DATA);
    cmp(q, 32'hC3);
    rd(`ASTR_OFS_CTL_THREE);
    cmp(q & 32'h2, 32'h0);
    nine = 1'b0;
    wr(`ASTR_OFS_CTL_ONE, 32'h01);
    i_astr_remote.send({2'b01, 8'hC3, 1'b0}, 10);
    wait_rx();
    rd(`ASTR_OFS_DATA);
    cmp(q, 32'hC3);
    rd(`ASTR_OFS_CTL_THREE);
    cmp(q & 32'h2, 32'h2);
    // incoming break: ten zeros, then rest
    i_astr_remote.send(12'h000, 10);
    wait_rx();
    cmp(q & 32'h24, 32'h24);
    rd(`ASTR_OFS_STAT_TWO);
    cmp(q & 32'h1, 32'h1);
    rd(`ASTR_OFS_DATA);
    cmp(q, 32'h0);
    rd(`ASTR_OFS_CTL_THREE);
    cmp(q & 32'h2, 32'h0);
    // outgoing breaks, normal and extended length
    for (int x = 0; x < 2; x++) begin
      wr(`ASTR_OFS_CTL_ONE, 32'h01 | (x << 3));
      wr(`ASTR_OFS_CTL_TWO, 32'h1F);
      repeat (600) @(posedge clk);
      wr(`ASTR_OFS_CTL_TWO, 32'h0F);
      repeat (500) @(posedge clk);
      cmp(32'(i_astr_remote.last_run % (16 * (10 + x))), 32'h0);
      cmp(32'(i_astr_remote.last_run >= 32 * (10 + x)), 32'h1);
      cmp({31'h0, line}, 32'h1);
    end
    // bus-clock source: start plus eight zero bits, 64 clocks each
    wr(`ASTR_OFS_CTL_ONE, 32'h11);
    rd(`ASTR_OFS_STAT_ONE);
    wr(`ASTR_OFS_DATA, 32'h00);
    repeat (900) @(posedge clk);
    cmp(i_astr_remote.last_run, 32'h240);
    // dropping the transmitter mid-frame still completes the character
    wr(`ASTR_OFS_CTL_ONE, 32'h01);
    rd(`ASTR_OFS_STAT_ONE);
    wr(`ASTR_OFS_DATA, 32'h5A);
    repeat (40) @(posedge clk);
    wr(`ASTR_OFS_CTL_TWO, 32'h0E);
    wait_tx();
    cmp({23'h0, i_astr_remote.frame[8:0]}, {23'h0, 1'b1, 8'h5A});
    wr(`ASTR_OFS_CTL_ONE, 32'h05);
    repeat (40) @(posedge clk);
    #1;
    cmp({31'h0, txd_o}, 32'h0);
    wr(`ASTR_OFS_CTL_ONE, 32'h04);
    #1;
    cmp({31'h0, txd_oe}, 32'h0);
    cmp({31'h0, rxd_oe}, 32'h0);
    summarize();
  end
endmodule : astr_serial_test
`default_nettype wire

//--- verilog/astr_serial.sv
// full-duplex asynchronous serial transmitter and receiver with apb registers
//
// Overview of operation
// - sends 8 or 9 data bits; ninth bit comes from tx_ninth_bit
// - each rise of transmitter enable queues an all-ones preamble before buffered data
// - frame has start bit 0 at lsb and stop bit 1 at msb
// - empty flag sets on buffer handover; tx irq while flag and enable set
// - data writes feed transmitter, data reads return received data
// - line rests at idle level, high unless inverted
// - clearing module enable releases both pins at once
// - send break loads all-zero character sized by length and extended break
// - break repeats while set; after clearing finish then send a one
// - normal break is 10 or 11 consecutive zeros
// - extended break is 11 or 12 consecutive zeros
// - break sets framing, full, break flags and clears buffer and ninth bit
// - idle character is all ones sized by the character length
// - clearing transmitter enable finishes the current character first
// - toggling transmitter enable mid-frame queues one idle character
// - inversion flips every transmitted bit
// - received ninth bit holds bit 8, or copy of bit 7 in 8-bit mode
// - complete character moves to buffer, sets full; rx irq when enabled
// - transmitter and receiver independent, sharing one baud generator
// - baud source select picks bus clock or four times bus clock
// - receiver samples at sixteen times baud, resynced at each start bit
// - missing stop bit sets framing flag with the full flag
`include "astr_map.svh"
`timescale 1ns/10ps
`default_nettype none
module astr_serial
  import astr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins
  output logic txd_o,
  output logic txd_oe,
  input wire logic rxd_i,
  output logic rxd_oe,
  // interrupt requests
  output logic tx_irq,
  output logic rx_irq
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [4:0] ctl_one_r;
  logic [4:0] ctl_two_r;
  logic tx_ninth_bit_r;
  logic rx_ninth_bit_r;
  logic [15:0] baud_r;
  logic tx_empty_r, tx_done_r, rx_full_r, overrun_r, noise_r, framing_r, break_r;
  logic [7:0] tx_buf_r, rx_buf_r;
  logic stat_seen_r;
  logic [31:0] prdata_r;

  wire module_enable = ctl_one_r[`ASTR_C1_ENABLE];
  wire nine_bit = ctl_one_r[`ASTR_C1_NINE];
  wire tx_polarity_flip = ctl_one_r[`ASTR_C1_FLIP];
  wire extended_break_select = ctl_one_r[`ASTR_C1_EXTBRK];
  wire baud_source_cfg = ctl_one_r[`ASTR_C1_BAUDSRC];
  wire tx_on = ctl_two_r[`ASTR_C2_TXON];
  wire rx_on = ctl_two_r[`ASTR_C2_RXON];
  wire send_break = ctl_two_r[`ASTR_C2_BREAK];

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire hit_c1 = paddr == `ASTR_OFS_CTL_ONE;
  wire hit_c2 = paddr == `ASTR_OFS_CTL_TWO;
  wire hit_c3 = paddr == `ASTR_OFS_CTL_THREE;
  wire hit_s1 = paddr == `ASTR_OFS_STAT_ONE;
  wire hit_s2 = paddr == `ASTR_OFS_STAT_TWO;
  wire hit_dat = paddr == `ASTR_OFS_DATA;
  wire hit_bd = paddr == `ASTR_OFS_BAUD;
  wire mapped = hit_c1 | hit_c2 | hit_c3 | hit_s1 | hit_s2 | hit_dat | hit_bd;
  wire rx_busy;
  wire [6:0] stat_one = {rx_busy, framing_r, noise_r, overrun_r, rx_full_r, tx_done_r,
                         tx_empty_r};
  wire [31:0] rd_mux = hit_c1 ? {27'h0000000, ctl_one_r} :
                       hit_c2 ? {27'h0000000, ctl_two_r} :
                       hit_c3 ? {30'h00000000, rx_ninth_bit_r, tx_ninth_bit_r} :
                       hit_s1 ? {25'h0000000, stat_one} :
                       hit_s2 ? {31'h00000000, break_r} :
                       hit_dat ? {24'h000000, rx_buf_r} :
                       hit_bd ? {16'h0000, baud_r} : 32'h00000000;
  // zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = prdata_r;
  wire data_wr = wr && hit_dat;
  wire data_rd = rd && hit_dat;
  // two-step clears: status read arms, the next data access clears
  wire clr_tx = data_wr && stat_seen_r;
  wire clr_rx = data_rd && stat_seen_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata_r <= 32'h00000000;
      stat_seen_r <= 1'b0;
    end else begin
      if (psel && !penable && !pwrite) begin
        prdata_r <= rd_mux;
      end
      if (rd && hit_s1) begin
        stat_seen_r <= 1'b1;
      end else if (acc && hit_dat) begin
        stat_seen_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl_one_r <= `ASTR_RST_CTL_ONE;
      ctl_two_r <= `ASTR_RST_CTL_TWO;
      tx_ninth_bit_r <= 1'b0;
      baud_r <= `ASTR_RST_BAUD;
      tx_buf_r <= 8'h00;
    end else begin
      if (wr && hit_c1) ctl_one_r <= pwdata[4:0];
      if (wr && hit_c2) ctl_two_r <= pwdata[4:0];
      if (wr && hit_c3) tx_ninth_bit_r <= pwdata[`ASTR_C3_TX9];
      if (wr && hit_bd) baud_r <= pwdata[15:0];
      if (data_wr) tx_buf_r <= pwdata[7:0];
    end
  end

  // ------------------------------------------------------------
  // shared baud generator: one sample tick per divisor count
  // ------------------------------------------------------------
  logic [1:0] quarter_r;
  logic [15:0] baud_cnt_r;
  // clk is the 4x oscillator clock; bus clock is every fourth edge
  wire src_en = !baud_source_cfg || (quarter_r == `ASTR_BUS_DIV);
  wire baud_wrap = baud_cnt_r + 16'h0001 >= baud_r;
  wire rt_tick = src_en && baud_wrap;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      quarter_r <= 2'h0;
      baud_cnt_r <= 16'h0000;
    end else begin
      quarter_r <= quarter_r + 2'h1;
      if (src_en) baud_cnt_r <= baud_wrap ? 16'h0000 : baud_cnt_r + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // transmitter
  // ------------------------------------------------------------
  astr_tx_state_e tx_st_r;
  logic [11:0] tx_sh_r;
  logic [3:0] tx_left_r, tx_rt_r;
  logic tx_on_d_r, idle_pend_r, last_brk_r, txd_r, txd_oe_r;
  wire tx_bit_tick = rt_tick && tx_rt_r == `ASTR_RT_PER_BIT;
  wire [3:0] frame_len = nine_bit ? 4'hB : 4'hA;
  wire frame_end = tx_st_r == ASTR_TX_IDLE || tx_left_r == 4'h1;
  wire tx_step = tx_bit_tick && frame_end && module_enable;
  wire ld_brk = tx_step && send_break && tx_on;
  wire ld_mark = tx_step && !ld_brk && last_brk_r;
  wire ld_idle = tx_step && !ld_brk && !ld_mark && idle_pend_r && tx_on;
  wire ld_data = tx_step && !ld_brk && !ld_mark && !idle_pend_r && tx_on && !tx_empty_r
                 && tx_on_d_r;
  wire tx_rose = tx_on && !tx_on_d_r;
  wire tx_bit = tx_st_r == ASTR_TX_SHIFT ? tx_sh_r[0] : 1'b1;
  // start bit 0 at lsb, stop bit 1 above the data
  wire [11:0] data_frame = nine_bit ? {1'b1, 1'b1, tx_ninth_bit_r, tx_buf_r, 1'b0} :
                                      {2'b11, 1'b1, tx_buf_r, 1'b0};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_st_r <= ASTR_TX_IDLE;
      tx_sh_r <= 12'hFFF;
      tx_left_r <= 4'h0;
      tx_rt_r <= 4'h0;
      tx_on_d_r <= 1'b0;
      idle_pend_r <= 1'b0;
      last_brk_r <= 1'b0;
    end else begin
      tx_on_d_r <= tx_on;
      if (rt_tick) tx_rt_r <= tx_rt_r + 4'h1;
      if (tx_rose) begin
        idle_pend_r <= 1'b1;
      end else if (ld_idle) begin
        idle_pend_r <= 1'b0;
      end
      if (!module_enable) begin
        tx_st_r <= ASTR_TX_IDLE;
        last_brk_r <= 1'b0;
      end else if (ld_brk) begin
        tx_st_r <= ASTR_TX_SHIFT;
        tx_sh_r <= 12'h000;
        tx_left_r <= frame_len + {3'h0, extended_break_select};
        last_brk_r <= 1'b1;
      end else if (ld_mark) begin
        tx_st_r <= ASTR_TX_SHIFT;
        tx_sh_r <= 12'hFFF;
        tx_left_r <= 4'h1;
        last_brk_r <= 1'b0;
      end else if (ld_idle) begin
        tx_st_r <= ASTR_TX_SHIFT;
        tx_sh_r <= 12'hFFF;
        tx_left_r <= frame_len;
      end else if (ld_data) begin
        tx_st_r <= ASTR_TX_SHIFT;
        tx_sh_r <= data_frame;
        tx_left_r <= frame_len;
      end else if (tx_bit_tick && tx_st_r == ASTR_TX_SHIFT) begin
        // finish the frame in progress even after tx_on falls
        tx_sh_r <= {1'b1, tx_sh_r[11:1]};
        tx_left_r <= tx_left_r - 4'h1;
        if (tx_left_r == 4'h1) tx_st_r <= ASTR_TX_IDLE;
      end
    end
  end

  // pin driven from flops; enable dropped as soon as the unit is off
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txd_r <= 1'b0;
      txd_oe_r <= 1'b0;
    end else begin
      txd_r <= module_enable ? tx_bit ^ tx_polarity_flip : 1'b0;
      txd_oe_r <= module_enable;
    end
  end
  assign txd_o = txd_r;
  assign txd_oe = txd_oe_r && module_enable;
  assign rxd_oe = 1'b0;

  // ------------------------------------------------------------
  // receiver
  // ------------------------------------------------------------
  astr_rx_state_e rx_st_r;
  logic rx_meta_r, rx_sync_r;
  logic [3:0] rx_rt_r, rx_idx_r;
  logic [2:0] smp_r;
  logic [8:0] rx_sh_r;
  logic rx_noise_r, rx_nz_r;
  wire rx_go = module_enable && rx_on;
  wire eval = rt_tick && rx_rt_r == 4'hA;
  wire [2:0] smp_all = {smp_r[1:0], rx_sync_r};
  wire maj = (smp_all[0] & smp_all[1]) | (smp_all[0] & smp_all[2]) | (smp_all[1] & smp_all[2]);
  wire smp_noisy = smp_all != 3'b000 && smp_all != 3'b111;
  wire [3:0] ndata = nine_bit ? 4'h9 : 4'h8;
  wire at_stop = rx_idx_r == ndata;
  wire all_zero = !rx_nz_r && !maj;
  wire stop_hit = rx_st_r == ASTR_RX_DATA && eval && at_stop;
  wire ext_hit = rx_st_r == ASTR_RX_DATA && eval && rx_idx_r == ndata + 4'h1;
  // extended break needs one more zero after the stop position
  wire ext_wait = stop_hit && all_zero && extended_break_select;
  wire rx_done = (stop_hit && !ext_wait) || ext_hit;
  wire brk_evt = rx_done && all_zero;
  wire fe_evt = rx_done && (ext_hit || !maj);
  wire [7:0] rx_data = nine_bit ? rx_sh_r[7:0] : rx_sh_r[8:1];
  assign rx_busy = rx_st_r != ASTR_RX_IDLE;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end else begin
      rx_meta_r <= rxd_i;
      rx_sync_r <= rx_meta_r;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_st_r <= ASTR_RX_IDLE;
      rx_rt_r <= 4'h0;
      rx_idx_r <= 4'h0;
      smp_r <= 3'h7;
      rx_sh_r <= 9'h000;
      rx_noise_r <= 1'b0;
      rx_nz_r <= 1'b0;
    end else if (!rx_go) begin
      rx_st_r <= ASTR_RX_IDLE;
    end else if (rt_tick) begin
      rx_rt_r <= rx_rt_r + 4'h1;
      smp_r <= smp_all;
      case (rx_st_r)
        ASTR_RX_IDLE: begin
          if (!rx_sync_r) begin
            rx_st_r <= ASTR_RX_START;
            rx_rt_r <= 4'h2;
            rx_noise_r <= 1'b0;
            rx_nz_r <= 1'b0;
          end
        end
        ASTR_RX_START: begin
          if (eval) begin
            rx_st_r <= maj ? ASTR_RX_IDLE : ASTR_RX_DATA;
            rx_idx_r <= 4'h0;
            rx_noise_r <= smp_noisy;
          end
        end
        ASTR_RX_DATA: begin
          if (eval) begin
            rx_idx_r <= rx_idx_r + 4'h1;
            rx_noise_r <= rx_noise_r | smp_noisy;
            if (!at_stop && !ext_hit) begin
              rx_sh_r <= {maj, rx_sh_r[8:1]};
              rx_nz_r <= rx_nz_r | maj;
            end
            if (rx_done) rx_st_r <= ASTR_RX_IDLE;
          end
        end
        default: rx_st_r <= ASTR_RX_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // status flags: a hardware set wins over a software clear
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_empty_r <= 1'b1;
      tx_done_r <= 1'b1;
      rx_full_r <= 1'b0;
      overrun_r <= 1'b0;
      noise_r <= 1'b0;
      framing_r <= 1'b0;
      break_r <= 1'b0;
      rx_buf_r <= 8'h00;
      rx_ninth_bit_r <= 1'b0;
    end else begin
      if (ld_data) tx_empty_r <= 1'b1;
      else if (clr_tx) tx_empty_r <= 1'b0;
      tx_done_r <= tx_st_r == ASTR_TX_IDLE && tx_empty_r;
      if (rx_done) begin
        rx_full_r <= 1'b1;
        overrun_r <= overrun_r | rx_full_r;
        noise_r <= noise_r | rx_noise_r | smp_noisy;
        framing_r <= framing_r | fe_evt;
        rx_buf_r <= brk_evt ? 8'h00 : rx_data;
        rx_ninth_bit_r <= brk_evt ? 1'b0 : rx_sh_r[8];
      end else if (clr_rx) begin
        rx_full_r <= 1'b0;
        overrun_r <= 1'b0;
        noise_r <= 1'b0;
        framing_r <= 1'b0;
      end
      if (brk_evt) break_r <= 1'b1;
      else if (wr && hit_s2 && pwdata[`ASTR_S2_BRK]) break_r <= 1'b0;
    end
  end

  assign tx_irq = tx_empty_r && ctl_two_r[`ASTR_C2_TIE];
  assign rx_irq = rx_full_r && ctl_two_r[`ASTR_C2_RIE];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_data_load;
    ld_data;
  endsequence
  sequence s_break_over;
    tx_step && last_brk_r && !send_break;
  endsequence

  a_tx_irq_level: assert property (@(posedge clk) disable iff (!resetn)
    s_data_load ##1 ctl_two_r[`ASTR_C2_TIE] |-> tx_irq) else $error("tx irq missing");
  a_rx_irq_level: assert property (@(posedge clk) disable iff (!resetn)
    rx_done |=> rx_full_r ##0 (rx_irq == ctl_two_r[`ASTR_C2_RIE])) else $error("rx irq wrong");
  a_empty_on_load: assert property (@(posedge clk) disable iff (!resetn)
    s_data_load |=> tx_empty_r) else $error("empty flag not set on load");
  a_frame_bits: assert property (@(posedge clk) disable iff (!resetn)
    s_data_load |=> !tx_sh_r[0] && tx_sh_r[tx_left_r - 4'h1]) else $error("bad frame bits");
  a_preamble_first: assert property (@(posedge clk) disable iff (!resetn)
    $rose(tx_on) |-> !ld_data [*2]) else $error("data before preamble");
  a_break_tail: assert property (@(posedge clk) disable iff (!resetn)
    s_break_over |=> tx_sh_r[0] && tx_left_r == 4'h1) else $error("no mark after break");
  a_pin_release: assert property (@(posedge clk) disable iff (!resetn)
    !module_enable |-> !txd_oe ##1 !txd_oe_r) else $error("pin held while disabled");
  a_idle_high: assert property (@(posedge clk) disable iff (!resetn)
    $past(tx_st_r == ASTR_TX_IDLE && module_enable && !tx_polarity_flip) |-> txd_r)
    else $error("idle level wrong");
  a_frame_flag: assert property (@(posedge clk) disable iff (!resetn)
    fe_evt |=> framing_r && rx_full_r) else $error("framing not with full");
  a_break_clear: assert property (@(posedge clk) disable iff (!resetn)
    brk_evt |=> rx_buf_r == 8'h00 && !rx_ninth_bit_r && break_r && framing_r)
    else $error("break effects missing");
endmodule : astr_serial
`default_nettype wire
